//--- inc/mss_pkg.sv
package mss_pkg;
  // Byte offsets on the register bus.
  localparam logic [7:0] MSS_FUNC_BASE = 8'h00;
  localparam logic [7:0] MSS_RAMP_LO_OFS = 8'h40;
  localparam logic [7:0] MSS_RAMP_HI_OFS = 8'h44;
  localparam logic [7:0] MSS_STEP_RD_OFS = 8'h48;
  localparam logic [7:0] MSS_TERM_RD_OFS = 8'h4C;
  localparam logic [7:0] MSS_STEP_BASE = 8'h80;
  // Input function codes.
  localparam logic [7:0] MSS_FN_STEP1 = 8'h10;
  localparam logic [7:0] MSS_FN_PAUSE = 8'h14;
  // Speed limits in 0.1 % units, and reset values.
  localparam logic signed [15:0] MSS_SPEED_MAX = 16'sh0BB8;
  localparam logic signed [15:0] MSS_SPEED_MIN = -16'sh0BB8;
  localparam logic [15:0] MSS_RST_WORD = 16'h0000;
  localparam logic [7:0] MSS_RST_FUNC = 8'h00;
  localparam logic [3:0] MSS_RST_STEP = 4'h0;
endpackage

//--- verilog/mss_selector.sv
`timescale 1ns/100ps
module mss_selector import mss_pkg::*; #(
  parameter int NUM_DI = 6
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [NUM_DI-1:0] din_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic signed [15:0] speed_ref_o,
  output logic [15:0] step_run_time_o,
  output logic [1:0] ramp_sel_o,
  output logic [3:0] active_step_o,
  output logic paused_o
);

  logic [7:0] func_q [NUM_DI];
  logic signed [15:0] speed_q [16];
  logic [15:0] time_q [16];
  logic [15:0] ramp_lo_q;
  logic [15:0] ramp_hi_q;
  logic [3:0] step_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [3:0] sel_idx;
  logic pause_now;
  logic [3:0] bit_hit [NUM_DI];
  logic [NUM_DI-1:0] pause_hit;
  logic wr_go;
  logic signed [15:0] wr_speed;
  logic [3:0] wr_step;

  // Each input contributes to a step bit or the pause only while active and mapped.
  genvar g;
  generate
    for (g = 0; g < NUM_DI; g++) begin : g_di
      for (genvar b = 0; b < 4; b++) begin : g_bit
        assign bit_hit[g][b] = din_i[g] && (func_q[g] == MSS_FN_STEP1 + 8'(b));
      end
      assign pause_hit[g] = din_i[g] && (func_q[g] == MSS_FN_PAUSE);
    end
  endgenerate

  // OR the hits of all inputs; an unmapped or inactive terminal leaves its bit zero.
  always_comb begin
    sel_idx = 4'h0;
    for (int i = 0; i < NUM_DI; i++) begin
      sel_idx = sel_idx | bit_hit[i];
    end
  end
  assign pause_now = |pause_hit;

  // The step index follows the terminals, but is frozen while paused.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      step_q <= MSS_RST_STEP;
    end else if (!pause_now) begin
      step_q <= sel_idx;
    end
  end

  // Bus handshake: one wait cycle, then the answer stands for one cycle.
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_go = avs_write_i && ack_q;
  assign wr_step = avs_address_i[6:3];
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  // Out-of-range speeds are clamped so the reference can never leave its band.
  always_comb begin
    wr_speed = avs_writedata_i[15:0];
    if (wr_speed > MSS_SPEED_MAX) begin
      wr_speed = MSS_SPEED_MAX;
    end else if (wr_speed < MSS_SPEED_MIN) begin
      wr_speed = MSS_SPEED_MIN;
    end
  end

  // Step table writes.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      for (int k = 0; k < 16; k++) begin
        speed_q[k] <= MSS_RST_WORD;
        time_q[k] <= MSS_RST_WORD;
      end
    end else if (wr_go && avs_address_i[7] && avs_address_i[1:0] == 2'h0) begin
      if (!avs_address_i[2]) begin
        speed_q[wr_step] <= wr_speed;
      end else begin
        time_q[wr_step] <= avs_writedata_i[15:0];
      end
    end
  end

  // Input function and ramp selection writes; any 16-bit ramp value is accepted.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ramp_lo_q <= MSS_RST_WORD;
      ramp_hi_q <= MSS_RST_WORD;
      for (int i = 0; i < NUM_DI; i++) begin
        func_q[i] <= MSS_RST_FUNC;
      end
    end else if (wr_go) begin
      if (avs_address_i == MSS_RAMP_LO_OFS) begin
        ramp_lo_q <= avs_writedata_i[15:0];
      end else if (avs_address_i == MSS_RAMP_HI_OFS) begin
        ramp_hi_q <= avs_writedata_i[15:0];
      end else begin
        for (int i = 0; i < NUM_DI; i++) begin
          if (avs_address_i == MSS_FUNC_BASE + 8'(4 * i)) begin
            func_q[i] <= avs_writedata_i[7:0];
          end
        end
      end
    end
  end

  // Read data is captured in the wait cycle; unmapped offsets read as zero.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      rdata_q <= 32'h0000_0000;
      if (avs_address_i == MSS_RAMP_LO_OFS) begin
        rdata_q <= {16'h0000, ramp_lo_q};
      end else if (avs_address_i == MSS_RAMP_HI_OFS) begin
        rdata_q <= {16'h0000, ramp_hi_q};
      end else if (avs_address_i == MSS_STEP_RD_OFS) begin
        rdata_q <= {28'h0000000, step_q};
      end else if (avs_address_i == MSS_TERM_RD_OFS) begin
        rdata_q <= {27'h0000000, pause_now, sel_idx};
      end else if (avs_address_i[7] && avs_address_i[1:0] == 2'h0) begin
        rdata_q <= avs_address_i[2] ? {16'h0000, time_q[wr_step]} : {{16{speed_q[wr_step][15]}}, speed_q[wr_step]};
      end else begin
        for (int i = 0; i < NUM_DI; i++) begin
          if (avs_address_i == MSS_FUNC_BASE + 8'(4 * i)) begin
            rdata_q <= {24'h000000, func_q[i]};
          end
        end
      end
    end
  end
  assign avs_readdata_o = rdata_q;

  // Reference outputs for the active step; the ramp choice is two bits per step.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      speed_ref_o <= MSS_RST_WORD;
      step_run_time_o <= MSS_RST_WORD;
      ramp_sel_o <= 2'h0;
      paused_o <= 1'b0;
    end else begin
      speed_ref_o <= speed_q[step_q];
      step_run_time_o <= time_q[step_q];
      ramp_sel_o <= step_q[3] ? ramp_hi_q[2*step_q[2:0] +: 2] : ramp_lo_q[2*step_q[2:0] +: 2];
      paused_o <= pause_now;
    end
  end
  assign active_step_o = step_q;

  property p_step_follow;
    @(posedge sys_clk_i) disable iff (!rstn_i) !pause_now |=> step_q == $past(sel_idx);
  endproperty
  a_step_follow: assert property (p_step_follow) else $error("step index did not follow terminals");

  property p_term_map;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (din_i[0] && func_q[0] == MSS_FN_STEP1 + 8'h03 && !pause_now) |=> step_q[3];
  endproperty
  a_term_map: assert property (p_term_map) else $error("terminal 4 not mapped to bit 3");

  property p_pause_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i) pause_now |=> $stable(step_q);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("step changed while paused");

  property p_speed_band;
    @(posedge sys_clk_i) disable iff (!rstn_i) speed_ref_o <= MSS_SPEED_MAX && speed_ref_o >= MSS_SPEED_MIN;
  endproperty
  a_speed_band: assert property (p_speed_band) else $error("speed reference out of band");

  property p_ramp_pick;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ##1 (ramp_sel_o == 2'(($past(step_q[3]) ? $past(ramp_hi_q) : $past(ramp_lo_q))
                            >> (2 * $past(step_q[2:0]))));
  endproperty
  a_ramp_pick: assert property (p_ramp_pick) else $error("ramp selection wrong");

  property p_step_read;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (avs_read_i && !ack_q && avs_address_i == MSS_STEP_RD_OFS) |=> avs_readdata_o == {28'h0000000, $past(step_q)};
  endproperty
  a_step_read: assert property (p_step_read) else $error("step readout wrong");

  property p_index_zero;
    @(posedge sys_clk_i) disable iff (!rstn_i) (din_i == '0 && !pause_now) |=> step_q == 4'h0;
  endproperty
  a_index_zero: assert property (p_index_zero) else $error("inactive terminals gave nonzero step");

  property p_answer;
    @(posedge sys_clk_i) disable iff (!rstn_i) ((avs_read_i || avs_write_i) && !ack_q) |=> !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

endmodule

//--- tb/mss_switch_model.sv
`timescale 1ns/100ps
// Switch bank in front of the terminals; wired in reverse so step bit j lands on input 3-j.
module mss_switch_model (
  input wire logic sys_clk_i,
  input wire logic [3:0] step_i,
  input wire logic pause_i,
  output logic [5:0] din_o
);
  // Known levels from time zero, so the spare toggle never starts unknown.
  logic [4:0] contact_q = 5'h00;
  logic spare_q = 1'b0;
  // Contacts change on clock edges only; the spare input flips every cycle so it must be ignored.
  always @(posedge sys_clk_i) begin
    contact_q[3:0] <= {step_i[0], step_i[1], step_i[2], step_i[3]};
    contact_q[4] <= pause_i;
    spare_q <= ~spare_q;
  end
  assign din_o = {spare_q, contact_q};
endmodule

//--- tb/mss_selector_tb_top.sv
`timescale 1ns/100ps
module mss_selector_tb_top import mss_pkg::*; ;
  typedef struct packed {logic [3:0] k; logic [15:0] spd; logic [15:0] tm;} mss_row_s;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, pause = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [5:0] din;
  logic [3:0] step = 4'h0, act;
  logic signed [15:0] spd;
  logic [15:0] tm, lo = 16'h1B6C, hi = 16'hC936, w;
  logic [1:0] rs;
  logic wt, pz;
  int n_errors = 0, cmp_count = 0;
  mss_row_s rows [4] = '{'{4'h0, 16'hF448, 16'hFFFF}, '{4'h7, 16'h0BB8, 16'h0000},
                         '{4'h8, 16'h0001, 16'h1234}, '{4'hF, 16'hFFFF, 16'h0001}};
  // Half-period toggle gives 100 MHz.
  always #5 clk = ~clk;
  mss_switch_model mss_switch_model_inst (.sys_clk_i(clk), .step_i(step), .pause_i(pause), .din_o(din));
  mss_selector mss_selector_inst (.sys_clk_i(clk), .rstn_i(rstn), .din_i(din), .avs_address_i(ad),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .speed_ref_o(spd), .step_run_time_o(tm), .ramp_sel_o(rs),
    .active_step_o(act), .paused_o(pz));
  // Final verdict; the only place the run ends.
  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compares with case equality so an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon access; request held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    rd <= !we;
    wr <= we;
    ad <= a;
    wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wt === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("[FAIL] %0t bus timeout", $time);
      summarize();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Sets the switches, then waits the fixed model, step and output register latency.
  task automatic sw(input logic [3:0] k, input logic p);
    @(posedge clk);
    step <= k;
    pause <= p;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    chk(act, 32'h0);
    bus(1'b0, MSS_STEP_BASE + 8'h7C, 32'h0); chk(q, 32'h0);
    bus(1'b0, MSS_RAMP_HI_OFS, 32'h0); chk(q, 32'h0);
    bus(1'b0, MSS_STEP_RD_OFS, 32'h0); chk(q, 32'h0);
    // Reversed wiring: input i carries terminal 4-i, input 4 pauses, input 5 stays unassigned.
    for (int i = 0; i < 4; i++) bus(1'b1, MSS_FUNC_BASE + 8'(4 * i), 32'(MSS_FN_STEP1 + 8'(3 - i)));
    bus(1'b1, MSS_FUNC_BASE + 8'h10, 32'(MSS_FN_PAUSE));
    bus(1'b0, MSS_FUNC_BASE + 8'h04, 32'h0); chk(q, 32'h12);
    bus(1'b1, MSS_RAMP_LO_OFS, {16'h0, lo});
    bus(1'b1, MSS_RAMP_HI_OFS, {16'h0, hi});
    bus(1'b0, MSS_RAMP_HI_OFS, 32'h0); chk(q, {16'h0, hi});
    foreach (rows[r]) begin
      bus(1'b1, MSS_STEP_BASE + 8'(8 * rows[r].k), {16'h0, rows[r].spd});
      bus(1'b1, MSS_STEP_BASE + 8'(8 * rows[r].k) + 8'h04, {16'h0, rows[r].tm});
      sw(rows[r].k, 1'b0);
      w = rows[r].k < 8 ? lo : hi;
      w = w >> (2 * rows[r].k[2:0]);
      chk(act, 32'(rows[r].k));
      chk({16'h0000, spd}, {16'h0000, rows[r].spd});
      chk(tm, 32'(rows[r].tm));
      chk(rs, 32'(w[1:0]));
      bus(1'b0, MSS_STEP_RD_OFS, 32'h0); chk(q, 32'(rows[r].k));
      bus(1'b0, MSS_STEP_BASE + 8'(8 * rows[r].k), 32'h0); chk(q, {{16{rows[r].spd[15]}}, rows[r].spd});
    end
    // Out-of-range speeds saturate at the limits.
    bus(1'b1, MSS_STEP_BASE + 8'h18, 32'h0000_0FA0);
    bus(1'b0, MSS_STEP_BASE + 8'h18, 32'h0); chk(q, 32'(MSS_SPEED_MAX));
    bus(1'b1, MSS_STEP_BASE + 8'h18, 32'hFFFF_F060);
    bus(1'b0, MSS_STEP_BASE + 8'h18, 32'h0); chk(q, 32'hFFFF_F448);
    bus(1'b0, 8'h60, 32'h0); chk(q, 32'h0);
    // Pause freezes the step, release lets the new selection through.
    sw(4'h5, 1'b0);
    sw(4'h9, 1'b1);
    chk(act, 32'h5);
    chk(pz, 32'h1);
    bus(1'b0, MSS_TERM_RD_OFS, 32'h0); chk(q, 32'h19);
    sw(4'h9, 1'b0);
    chk(act, 32'h9);
    chk(pz, 32'h0);
    // A reset in mid-run clears the map, the step table and the ramp words.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(act, 32'h0);
    bus(1'b0, MSS_STEP_BASE + 8'h78, 32'h0); chk(q, 32'h0);
    bus(1'b0, MSS_RAMP_LO_OFS, 32'h0); chk(q, 32'h0);
    bus(1'b0, MSS_FUNC_BASE, 32'h0); chk(q, 32'h0);
    summarize();
  end
endmodule
